// File: verilog/ustf_defs.svh
/*
  constants for the upstream superframe timing block: counts, codes, sizes.
  assumes inclusion by bare name from the package and the design file.
*/
`ifndef USTF_DEFS_SVH
`define USTF_DEFS_SVH
`define USTF_PROBE_SYMS 9'h006
`define USTF_DATA_SYMS 9'h100
`define USTF_RB_SHORT 5'h08
`define USTF_RB_LONG 5'h10
`define USTF_NUM_SC 4096
`define USTF_CODE_EXCLUDED 4'hF
`define USTF_CODE_BPSK 4'h1
`define USTF_CODE_NULL 4'h0
`define USTF_MARKER_LEN 3
`define USTF_PID_W 15
`define USTF_PID_N 8
`define USTF_FRM_W 16
`endif

// File: verilog/ustf_pkg.sv
/*
  types for the upstream superframe timing block.
  assumes ustf_defs.svh is on the include path.
*/
`include "ustf_defs.svh"
package ustf_pkg;
  typedef enum logic [1:0] {
    USTF_PROBE = 2'b00,
    USTF_DATA = 2'b01
  } ustf_state_t;

  typedef enum logic [2:0] {
    USTF_RB_EX = 3'h0,
    USTF_RB_T0 = 3'h1,
    USTF_RB_T1 = 3'h2,
    USTF_RB_T2 = 3'h3,
    USTF_RB_SM = 3'h4,
    USTF_RB_EM = 3'h5
  } ustf_rb_type_t;

  typedef struct packed {
    logic excluded;
    logic null_sc;
    logic bpsk;
    logic data_ok;
    logic [4:0] bits;
  } ustf_sc_info_t;

  typedef struct packed {
    logic equalize;
    logic [2:0] skip;
    logic [2:0] first_sc;
  } ustf_probe_cfg_t;
endpackage : ustf_pkg

// File: verilog/ustf_timing.sv
/*
  upstream superframe frame timing, subcarrier code table, resource block type
  selection for burst edges and probe generator settings.
  assumes i_sym_tick is a one-cycle pulse per extended symbol taken from the falling
  edge of the symbol clock, and that all inputs are synchronous to I_MCLK.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ustf_defs.svh"
module ustf_timing
  import ustf_pkg::*;
#(
  parameter int NUM_SC = `USTF_NUM_SC,
  parameter int PID_N = `USTF_PID_N
) (
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  input wire logic i_sym_tick,
  input wire logic i_superframe_restart,
  input wire logic i_block_duration_select,
  input wire logic i_code_we,
  input wire logic [11:0] i_code_addr,
  input wire logic [3:0] i_subcarrier_modulation_code,
  input wire logic [11:0] i_sc_index,
  input wire logic [2:0] i_pilot_type,
  input wire logic i_cont_pilot,
  input wire logic i_burst_first,
  input wire logic i_burst_last,
  input wire logic i_probe_symbol,
  input wire logic i_probe_equalize,
  input wire logic [2:0] i_probe_skip_count,
  input wire logic [2:0] i_probe_first_subcarrier,
  input wire logic i_pid_we,
  input wire logic [2:0] i_pid_addr,
  input wire logic [`USTF_PID_W-1:0] i_probe_identifier,
  input wire logic [`USTF_FRM_W-1:0] i_upstream_frame_counter,
  input wire logic [`USTF_FRM_W-1:0] i_target_frame_identifier,
  output logic O_PROBE_START,
  output logic O_BLOCK_FRAME_FIRST_SYMBOL_FLAG,
  output logic O_PROBE_REGION,
  output logic [8:0] O_SUPERFRAME_SYMBOL_COUNTER,
  output logic [4:0] O_BLOCK_SYMBOL_LENGTH,
  output logic [2:0] O_RB_TYPE,
  output ustf_sc_info_t O_SC_INFO,
  output logic O_ZERO_AMPLITUDE,
  output logic O_CONFIG_ERROR,
  output ustf_probe_cfg_t O_PROBE_CFG,
  output logic O_PROBE_SC_USED,
  output logic [PID_N*`USTF_PID_W-1:0] O_ACTIVE_PROBE_ID_SET
);
  ustf_state_t state_reg;
  logic [8:0] symbol_counter_reg;
  logic [4:0] symbols_per_block_frame_reg;
  logic [4:0] block_symbol_length;
  logic restart_d_reg;
  logic restart_pend_reg;
  logic dur_d_reg;
  logic [3:0] code_mem [NUM_SC];
  logic [3:0] code_rd;
  logic [3:0] code_prev;
  logic [3:0] code_nxt;
  logic edge_adj;
  logic [`USTF_PID_W-1:0] rcv_pid [PID_N];
  logic [`USTF_PID_W-1:0] act_pid [PID_N];

  assign block_symbol_length = i_block_duration_select ? `USTF_RB_LONG : `USTF_RB_SHORT;

  // a restart edge or a duration change arms a pending restart taken at the next tick
  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST)
    begin
      restart_d_reg <= 1'b0;
      // seeded from the pin so a select held through reset arms no restart
      dur_d_reg <= i_block_duration_select;
      restart_pend_reg <= 1'b0;
    end
    else
    begin
      restart_d_reg <= i_superframe_restart;
      dur_d_reg <= i_block_duration_select;
      if ((i_superframe_restart && !restart_d_reg) || (dur_d_reg != i_block_duration_select))
        restart_pend_reg <= 1'b1;
      else if (i_sym_tick)
        restart_pend_reg <= 1'b0;
    end
  end

  // counter advances only on the symbol tick, one per extended symbol
  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST)
    begin
      state_reg <= USTF_PROBE;
      symbol_counter_reg <= 9'h000;
      symbols_per_block_frame_reg <= block_symbol_length;
    end
    else if (i_sym_tick)
    begin
      if (restart_pend_reg)
      begin
        state_reg <= USTF_PROBE;
        symbol_counter_reg <= 9'h000;
        symbols_per_block_frame_reg <= block_symbol_length;
      end
      else
      begin
        case (state_reg)
          USTF_PROBE:
          begin
            if (symbol_counter_reg == `USTF_PROBE_SYMS - 9'h001)
            begin
              state_reg <= USTF_DATA;
              symbol_counter_reg <= 9'h000;
            end
            else
              symbol_counter_reg <= symbol_counter_reg + 9'h001;
          end
          USTF_DATA:
          begin
            if (symbol_counter_reg == `USTF_DATA_SYMS - 9'h001)
            begin
              state_reg <= USTF_PROBE;
              symbol_counter_reg <= 9'h000;
            end
            else
              symbol_counter_reg <= symbol_counter_reg + 9'h001;
          end
          default:
          begin
            state_reg <= USTF_PROBE;
            symbol_counter_reg <= 9'h000;
          end
        endcase
      end
    end
  end

  // flags describe the current symbol; registered from the same state so they track it
  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST)
    begin
      O_PROBE_START <= 1'b0;
      O_BLOCK_FRAME_FIRST_SYMBOL_FLAG <= 1'b0;
      O_PROBE_REGION <= 1'b0;
      O_SUPERFRAME_SYMBOL_COUNTER <= 9'h000;
      O_BLOCK_SYMBOL_LENGTH <= block_symbol_length;
    end
    else
    begin
      O_PROBE_START <= (state_reg == USTF_PROBE) && (symbol_counter_reg == 9'h000);
      O_BLOCK_FRAME_FIRST_SYMBOL_FLAG <= (state_reg == USTF_DATA) &&
        ((symbols_per_block_frame_reg == `USTF_RB_LONG) ? (symbol_counter_reg[3:0] == 4'h0)
                                                        : (symbol_counter_reg[2:0] == 3'h0));
      O_PROBE_REGION <= (state_reg == USTF_PROBE);
      O_SUPERFRAME_SYMBOL_COUNTER <= symbol_counter_reg;
      O_BLOCK_SYMBOL_LENGTH <= symbols_per_block_frame_reg;
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (i_code_we)
      code_mem[i_code_addr] <= i_subcarrier_modulation_code;
  end

  // neighbours outside the table count as excluded so the channel ends are band edges
  assign code_rd = code_mem[i_sc_index];
  assign code_prev = (i_sc_index == 12'h000) ? `USTF_CODE_EXCLUDED : code_mem[i_sc_index - 12'h001];
  assign code_nxt = (i_sc_index == 12'hFFF) ? `USTF_CODE_EXCLUDED : code_mem[i_sc_index + 12'h001];
  assign edge_adj = (code_prev == `USTF_CODE_EXCLUDED) || (code_nxt == `USTF_CODE_EXCLUDED);

  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST)
    begin
      O_SC_INFO <= '0;
      O_RB_TYPE <= USTF_RB_EX;
      O_ZERO_AMPLITUDE <= 1'b1;
      O_CONFIG_ERROR <= 1'b0;
    end
    else
    begin
      O_SC_INFO.excluded <= (code_rd == `USTF_CODE_EXCLUDED);
      O_SC_INFO.null_sc <= (code_rd == `USTF_CODE_NULL);
      O_SC_INFO.bpsk <= (code_rd == `USTF_CODE_BPSK);
      O_SC_INFO.data_ok <= (code_rd >= 4'h2) && (code_rd <= 4'hE);
      O_SC_INFO.bits <= (code_rd >= 4'h2 && code_rd <= 4'hE) ? {1'b0, code_rd} : 5'h00;
      // excluded never radiates; null radiates only as a probe symbol
      O_ZERO_AMPLITUDE <= (code_rd == `USTF_CODE_EXCLUDED) ||
                          ((code_rd == `USTF_CODE_NULL) && !i_probe_symbol);
      O_CONFIG_ERROR <= (code_rd == `USTF_CODE_BPSK) && !i_cont_pilot;
      if (code_rd == `USTF_CODE_EXCLUDED)
        O_RB_TYPE <= USTF_RB_EX;
      else if (i_burst_first || i_burst_last || edge_adj)
        O_RB_TYPE <= USTF_RB_T2;
      else if (i_pilot_type == USTF_RB_T0 || i_pilot_type == USTF_RB_T1 ||
               i_pilot_type == USTF_RB_T2)
        O_RB_TYPE <= i_pilot_type;
      else
        O_RB_TYPE <= USTF_RB_T0;
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST)
    begin
      O_PROBE_CFG <= '0;
      O_PROBE_SC_USED <= 1'b0;
    end
    else
    begin
      O_PROBE_CFG.equalize <= i_probe_equalize;
      O_PROBE_CFG.skip <= i_probe_skip_count;
      O_PROBE_CFG.first_sc <= i_probe_first_subcarrier;
      // used carriers step by skip+1 from the first one
      O_PROBE_SC_USED <= (i_sc_index >= {9'h000, i_probe_first_subcarrier}) &&
        ((12'(i_sc_index - {9'h000, i_probe_first_subcarrier}) %
          12'({9'h000, i_probe_skip_count} + 12'h001)) == 12'h000) &&
        (code_rd != `USTF_CODE_EXCLUDED);
    end
  end

  genvar g;
  generate
    for (g = 0; g < PID_N; g++)
    begin : g_pid
      always_ff @(posedge I_MCLK)
      begin
        if (I_SYS_RST)
        begin
          rcv_pid[g] <= '0;
          act_pid[g] <= '0;
        end
        else
        begin
          if (i_pid_we && (i_pid_addr == 3'(g)))
            rcv_pid[g] <= i_probe_identifier;
          if (i_upstream_frame_counter == i_target_frame_identifier)
            act_pid[g] <= rcv_pid[g];
        end
      end
      assign O_ACTIVE_PROBE_ID_SET[g*`USTF_PID_W +: `USTF_PID_W] = act_pid[g];
    end
  endgenerate

  property p_probe_start_first;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      O_PROBE_START |-> O_PROBE_REGION && (O_SUPERFRAME_SYMBOL_COUNTER == 9'h000);
  endproperty
  a_probe_start_first: assert property (p_probe_start_first) else $error("probe start off first");

  property p_frame_not_probe;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      O_BLOCK_FRAME_FIRST_SYMBOL_FLAG |-> !O_PROBE_REGION && !O_PROBE_START;
  endproperty
  a_frame_not_probe: assert property (p_frame_not_probe) else $error("frame flag in probe");

  property p_probe_len;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (i_sym_tick && !restart_pend_reg && state_reg == USTF_PROBE && symbol_counter_reg == 9'h005)
      |=> state_reg == USTF_DATA && symbol_counter_reg == 9'h000;
  endproperty
  a_probe_len: assert property (p_probe_len) else $error("probe period not six");

  property p_wrap;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (i_sym_tick && !restart_pend_reg && state_reg == USTF_DATA && symbol_counter_reg == 9'h0FF)
      |=> state_reg == USTF_PROBE && symbol_counter_reg == 9'h000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap after 256");

  property p_restart;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (i_sym_tick && restart_pend_reg) |=> state_reg == USTF_PROBE && symbol_counter_reg == 9'h000
        && symbols_per_block_frame_reg == $past(block_symbol_length);
  endproperty
  a_restart: assert property (p_restart) else $error("restart not taken");

  property p_hold;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      !i_sym_tick |=> $stable(symbol_counter_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without tick");

  property p_excluded_zero;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      O_SC_INFO.excluded |-> O_ZERO_AMPLITUDE && O_RB_TYPE == USTF_RB_EX;
  endproperty
  a_excluded_zero: assert property (p_excluded_zero) else $error("excluded radiates");

  property p_burst_t2;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (i_burst_first || i_burst_last) && code_rd != `USTF_CODE_EXCLUDED |=> O_RB_TYPE == USTF_RB_T2;
  endproperty
  a_burst_t2: assert property (p_burst_t2) else $error("burst edge not type 2");
endmodule : ustf_timing
`default_nettype wire

// File: bench/ustf_sym_model.sv
/*
  link-side symbol clock model: a one-cycle tick per modelled symbol period.
  assumes the bench enables it with i_run and samples on the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ustf_sym_model
#(
  parameter int SYM_CYC = 4
) (
  input wire logic i_clk,
  input wire logic i_run,
  output logic o_sym_tick
);
  int cnt = 0;
  initial o_sym_tick = 1'b0;
  // the symbol clock stands still while idle, so no stray tick leaks out
  always @(negedge i_clk)
  begin
    cnt <= (!i_run || cnt == SYM_CYC - 1) ? 0 : cnt + 1;
    o_sym_tick <= i_run && cnt == SYM_CYC / 2 - 1;
  end
endmodule : ustf_sym_model
`default_nettype wire

// File: bench/upstream_superframe_timing_test.sv
/*
  self-checking bench for the superframe timing block: timing, codes, probe, ids.
  assumes ustf_pkg and ustf_timing are compiled first; inputs move on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module upstream_superframe_timing_test;
  import ustf_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, restart = 1'b0, dur = 1'b0, run = 1'b0;
  logic code_we = 1'b0, cont = 1'b0, first = 1'b0, last = 1'b0, peq = 1'b0, pid_we = 1'b0;
  logic psym = 1'b1;
  logic [11:0] caddr = 12'h000, idx = 12'h000;
  logic [3:0] code = 4'h0;
  logic [2:0] ptype = 3'h0, skip = 3'h0, fsc = 3'h0, paddr = 3'h0;
  logic [14:0] pid = 15'h0000;
  logic [15:0] frm = 16'h0001, tgt = 16'h0002;
  wire logic tick;
  logic pstart, ffirst, preg, zamp, cerr, used;
  logic [8:0] cnt;
  logic [4:0] len;
  logic [2:0] rbt;
  ustf_sc_info_t info;
  ustf_probe_cfg_t pcfg;
  logic [119:0] act, act_exp;
  int bad_count = 0, n_compared = 0;

  initial forever #10 mclk = ~mclk;

  ustf_sym_model #(.SYM_CYC(4)) i_link (.i_clk(mclk), .i_run(run), .o_sym_tick(tick));

  ustf_timing i_dut (
    .I_MCLK(mclk), .I_SYS_RST(sys_rst), .i_sym_tick(tick), .i_superframe_restart(restart),
    .i_block_duration_select(dur), .i_code_we(code_we), .i_code_addr(caddr),
    .i_subcarrier_modulation_code(code), .i_sc_index(idx), .i_pilot_type(ptype),
    .i_cont_pilot(cont), .i_burst_first(first), .i_burst_last(last), .i_probe_symbol(psym),
    .i_probe_equalize(peq), .i_probe_skip_count(skip), .i_probe_first_subcarrier(fsc),
    .i_pid_we(pid_we), .i_pid_addr(paddr), .i_probe_identifier(pid),
    .i_upstream_frame_counter(frm), .i_target_frame_identifier(tgt),
    .O_PROBE_START(pstart), .O_BLOCK_FRAME_FIRST_SYMBOL_FLAG(ffirst), .O_PROBE_REGION(preg),
    .O_SUPERFRAME_SYMBOL_COUNTER(cnt), .O_BLOCK_SYMBOL_LENGTH(len), .O_RB_TYPE(rbt),
    .O_SC_INFO(info), .O_ZERO_AMPLITUDE(zamp), .O_CONFIG_ERROR(cerr), .O_PROBE_CFG(pcfg),
    .O_PROBE_SC_USED(used), .O_ACTIVE_PROBE_ID_SET(act)
  );

  task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic test_done;
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // waits for the tick edge, then one more edge for the registered flags
  task automatic step;
    int w;
    w = 0;
    @(posedge mclk);
    while (tick !== 1'b1 && w < 50)
    begin
      w++;
      @(posedge mclk);
    end
    cmp(w < 50, 1'b1);
    @(posedge mclk);
    @(negedge mclk);
  endtask : step

  task automatic chk_pos(input int k, input int l);
    cmp(pstart, k == 0);
    cmp(ffirst, k >= 6 && (k - 6) % l == 0);
    cmp(preg, k < 6);
    cmp(cnt, k < 6 ? k : k - 6);
    cmp(len, l);
  endtask : chk_pos

  task automatic sframe(input int l);
    for (int k = 1; k <= 262; k++)
    begin
      step();
      chk_pos(k % 262, l);
    end
  endtask : sframe

  task automatic wr(input int a, input int c);
    @(negedge mclk);
    code_we = 1'b1;
    caddr = 12'(a);
    code = 4'(c);
    @(negedge mclk);
    code_we = 1'b0;
  endtask : wr

  task automatic look(input int i);
    @(negedge mclk);
    idx = 12'(i);
    @(negedge mclk);
  endtask : look

  task automatic t_timing;
    repeat (20) @(negedge mclk);
    cmp({pstart, ffirst, cnt, len, rbt, zamp}, {2'b00, 9'h000, 5'h08, 3'h0, 1'b1});
    cmp(act, 120'h0);
    sys_rst = 1'b0;
    repeat (2) @(negedge mclk);
    chk_pos(0, 8);
    run = 1'b1;
    sframe(8);
    repeat (10) step();
    restart = 1'b1;
    @(negedge mclk);
    cmp(cnt, 4);
    step();
    chk_pos(0, 8);
    restart = 1'b0;
    dur = 1'b1;
    step();
    chk_pos(0, 16);
    sframe(16);
    run = 1'b0;
    // reset again with the long duration selected: the frame length must follow the pin
    sys_rst = 1'b1;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (2) @(negedge mclk);
    chk_pos(0, 16);
    run = 1'b1;
    for (int k = 1; k <= 14; k++)
    begin
      step();
      chk_pos(k, 16);
    end
    run = 1'b0;
  endtask : t_timing

  task automatic t_codes;
    for (int a = 0; a < 16; a++) wr(a, a);
    for (int a = 0; a < 16; a++)
    begin
      look(a);
      cmp(info.excluded, a == 15);
      cmp(info.null_sc, a == 0);
      cmp(info.bpsk, a == 1);
      cmp(zamp, a == 15);
      cmp(cerr, a == 1);
      cmp(info.data_ok, a > 1 && a < 15);
      if (a > 1 && a < 15) cmp(info.bits, a);
    end
    cont = 1'b1;
    look(1);
    cmp(cerr, 1'b0);
    cont = 1'b0;
    psym = 1'b0;
    look(0);
    cmp(zamp, 1'b1);
    look(2);
    cmp(zamp, 1'b0);
    psym = 1'b1;
  endtask : t_codes

  task automatic t_blocks;
    for (int a = 16; a < 24; a++) wr(a, 4);
    wr(24, 15);
    ptype = 3'h1;
    for (int a = 16; a < 24; a++)
    begin
      look(a);
      cmp(rbt, (a == 16 || a == 23) ? USTF_RB_T2 : USTF_RB_T0);
    end
    for (int t = 0; t < 4; t++)
    begin
      ptype = 3'(t);
      look(19);
      cmp(rbt, t == 0 ? 1 : t);
    end
    ptype = 3'h1;
    first = 1'b1;
    look(19);
    cmp(rbt, USTF_RB_T2);
    first = 1'b0;
    last = 1'b1;
    look(19);
    cmp(rbt, USTF_RB_T2);
    last = 1'b0;
  endtask : t_blocks

  task automatic t_probe;
    peq = 1'b1;
    skip = 3'h2;
    fsc = 3'h3;
    for (int a = 0; a < 25; a++)
    begin
      look(a);
      cmp(used, a >= 3 && (a - 3) % 3 == 0 && a != 15 && a != 24);
    end
    cmp(pcfg, 7'b1_010_011);
    peq = 1'b0;
    skip = 3'h7;
    look(0);
    cmp(pcfg, 7'b0_111_011);
  endtask : t_probe

  task automatic t_ids;
    for (int g = 0; g < 8; g++)
    begin
      @(negedge mclk);
      pid_we = 1'b1;
      paddr = 3'(g);
      pid = 15'h0100 + 15'(g);
      act_exp[g*15 +: 15] = pid;
    end
    @(negedge mclk);
    pid_we = 1'b0;
    @(negedge mclk);
    cmp(act, 120'h0);
    frm = tgt;
    repeat (2) @(negedge mclk);
    cmp(act, act_exp);
  endtask : t_ids

  initial
  begin
    t_timing();
    t_codes();
    t_blocks();
    t_probe();
    t_ids();
    test_done();
  end

  initial
  begin
    #200000;
    bad_count++;
    test_done();
  end
endmodule : upstream_superframe_timing_test
`default_nettype wire
